// >>> rtl/ssx_datapath.sv
// Purpose: execution datapath for sub, swap and xor with prefix widening
// Assumes: decoder presents one request per cycle; 20 MHz clock
// Notes: status word, boot select and last result reachable over axi4-lite
//
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Operation
// - plain sub: rd minus rs, one cycle
// - one prefix: rs minus 13-bit immediate
// - two prefixes: rs minus 26-bit immediate
// - immediate sub: rd minus unsigned 6-bit
// - one prefix: rd minus 19-bit immediate
// - two prefixes: rd minus 32-bit immediate
// - sp minus field times four, no prefix
// - swap reverses source bytes into destination
// - delay-slot forms must not be prefixed
// - plain xor: rd xor rs
// - one prefix: rs xor zero-extended 13 bits
// - two prefixes: rs xor zero-extended 26 bits
// - immediate xor sign-extends 6-bit field
// - one prefix: sign-extended 19-bit xor
// - two prefixes: signed 32-bit xor
// - trap base by boot source
// - fixed vector offsets, four-byte steps
module ssx_datapath
(
   input wire logic I_CLOCK,
   input wire logic I_RST_B,
   input wire ssx_pkg::ssx_req_t I_REQ,
   output ssx_pkg::ssx_res_t O_RES,
   input wire logic [7:0] I_VEC_SEL,
   output logic [31:0] O_VEC_ADDR,
   output logic [31:0] O_PSW,
   input wire logic [31:0] I_AWADDR,
   input wire logic I_AWVALID,
   output logic O_AWREADY,
   input wire logic [31:0] I_WDATA,
   input wire logic [3:0] I_WSTRB,
   input wire logic I_WVALID,
   output logic O_WREADY,
   output logic [1:0] O_BRESP,
   output logic O_BVALID,
   input wire logic I_BREADY,
   input wire logic [31:0] I_ARADDR,
   input wire logic I_ARVALID,
   output logic O_ARREADY,
   output logic [31:0] O_RDATA,
   output logic [1:0] O_RRESP,
   output logic O_RVALID,
   input wire logic I_RREADY
);
   import ssx_pkg::*;

   // ****************************************
   // reset release
   // ****************************************
   logic rst_meta_reg;
   logic rst_sync_reg;
   always_ff @(posedge I_CLOCK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end
   wire rst_n = rst_sync_reg;

   function automatic logic [31:0] swap_bytes(input logic [31:0] v);
      swap_bytes = {v[7:0], v[15:8], v[23:16], v[31:24]};
   endfunction : swap_bytes

   // ****************************************
   // operand widening
   // ****************************************
   wire one_ext = (I_REQ.ext_count == 2'd1);
   wire two_ext = (I_REQ.ext_count == 2'd2);
   wire [5:0] short_field = I_REQ.field[5:0];
   wire [31:0] rr_imm = two_ext ? {6'h00, I_REQ.prefix_first, I_REQ.prefix_second}
      : {19'h0_0000, I_REQ.prefix_first};
   wire [31:0] sub_imm = two_ext ? {I_REQ.prefix_first, I_REQ.prefix_second, short_field}
      : one_ext ? {13'h0000, I_REQ.prefix_first, short_field}
      : {26'h000_0000, short_field};
   wire [18:0] sign19 = {I_REQ.prefix_first, short_field};
   wire [31:0] xor_imm = two_ext ? {I_REQ.prefix_first, I_REQ.prefix_second, short_field}
      : one_ext ? {{13{sign19[18]}}, sign19}
      : {{26{short_field[5]}}, short_field};
   wire [31:0] sp_step = {20'h0_0000, I_REQ.field, 2'b00};
   wire no_ext = (I_REQ.ext_count == 2'd0);
   wire ext_forbidden = (I_REQ.op == SSX_OP_SUB_SP) || (I_REQ.op == SSX_OP_SWAP)
      || I_REQ.delay_slot;

   // ****************************************
   // result select
   // ****************************************
   ssx_res_t res_next;
   always_comb
   begin
      res_next = '0;
      res_next.rd_we = I_REQ.valid;
      case (I_REQ.op)
         SSX_OP_SUB_RR: res_next.data = no_ext ? I_REQ.rd_val - I_REQ.rs_val
            : I_REQ.rs_val - rr_imm;
         SSX_OP_SUB_RI: res_next.data = I_REQ.rd_val - sub_imm;
         SSX_OP_SUB_SP:
         begin
            res_next.data = I_REQ.sp_val - sp_step;
            res_next.rd_we = 1'b0;
            res_next.sp_we = I_REQ.valid;
         end
         SSX_OP_SWAP: res_next.data = swap_bytes(I_REQ.rs_val);
         SSX_OP_XOR_RR: res_next.data = no_ext ? I_REQ.rd_val ^ I_REQ.rs_val
            : I_REQ.rs_val ^ rr_imm;
         SSX_OP_XOR_RI: res_next.data = I_REQ.rd_val ^ xor_imm;
         SSX_OP_NONE: res_next.rd_we = 1'b0;
         default: res_next.rd_we = 1'b0;
      endcase
      if (I_REQ.valid && !no_ext && ext_forbidden)
      begin
         res_next.rd_we = 1'b0;
         res_next.sp_we = 1'b0;
         res_next.illegal = 1'b1;
      end
   end

   ssx_res_t res_reg;
   always_ff @(posedge I_CLOCK or negedge rst_n)
   begin
      if (!rst_n)
         res_reg <= '0;
      else
         res_reg <= res_next;
   end
   assign O_RES = res_reg;

   // ****************************************
   // flags and status word
   // ****************************************
   wire is_sub = (I_REQ.op == SSX_OP_SUB_RR) || (I_REQ.op == SSX_OP_SUB_RI);
   wire is_xor = (I_REQ.op == SSX_OP_XOR_RR) || (I_REQ.op == SSX_OP_XOR_RI);
   wire [31:0] minuend = (I_REQ.op == SSX_OP_SUB_RR && !no_ext) ? I_REQ.rs_val : I_REQ.rd_val;
   wire [31:0] subtra = (I_REQ.op == SSX_OP_SUB_RI) ? sub_imm : no_ext ? I_REQ.rs_val : rr_imm;
   wire borrow = (minuend < subtra);
   wire sub_ovf = (minuend[31] != subtra[31]) && (res_next.data[31] != minuend[31]);
   wire flag_upd = res_next.rd_we && (is_sub || is_xor);

   logic [31:0] psw_reg;
   logic boot_ext_reg;
   logic [31:0] last_reg;
   wire wr_fire;
   wire [31:0] bus_wdata;
   wire [31:0] wr_addr;
   // decode the held address, the live one may already have moved on
   wire psw_wr = wr_fire && (wr_addr[3:0] == SSX_ADDR_PSW);
   wire boot_wr = wr_fire && (wr_addr[3:0] == SSX_ADDR_BOOT);
   wire [31:0] psw_sw = (psw_reg & ~SSX_PSW_WMASK) | (bus_wdata & SSX_PSW_WMASK);
   logic [31:0] psw_next;
   always_comb
   begin
      psw_next = psw_wr ? psw_sw : psw_reg;
      if (flag_upd)
      begin
         psw_next[SSX_PSW_N] = res_next.data[31];
         psw_next[SSX_PSW_Z] = (res_next.data == 32'h0000_0000);
         if (is_sub)
         begin
            psw_next[SSX_PSW_C] = borrow;
            psw_next[SSX_PSW_V] = sub_ovf;
         end
      end
   end

   always_ff @(posedge I_CLOCK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         psw_reg <= SSX_PSW_RESET;
         boot_ext_reg <= 1'b0;
         last_reg <= 32'h0000_0000;
      end
      else
      begin
         psw_reg <= psw_next;
         if (boot_wr)
            boot_ext_reg <= bus_wdata[0];
         if (res_next.rd_we || res_next.sp_we)
            last_reg <= res_next.data;
      end
   end
   assign O_PSW = psw_reg;

   // ****************************************
   // trap vectors
   // ****************************************
   wire [31:0] trap_base = boot_ext_reg ? SSX_TRAP_BASE_EXT : SSX_TRAP_BASE_INT;
   logic [31:0] vec_off;
   always_comb
   begin
      case (I_VEC_SEL[7:6])
         2'b00: vec_off = SSX_VEC_RESET;
         2'b01: vec_off = (I_VEC_SEL[1:0] == 2'd1) ? SSX_VEC_ZDIV
            : (I_VEC_SEL[1:0] == 2'd2) ? SSX_VEC_ADDR_ERR
            : (I_VEC_SEL[1:0] == 2'd3) ? SSX_VEC_NMI : SSX_VEC_RESET;
         2'b10: vec_off = SSX_VEC_SWEXC0 + {28'h000_0000, I_VEC_SEL[1:0], 2'b00};
         default: vec_off = SSX_VEC_EXTINT0 + {22'h00_0000, I_VEC_SEL, 2'b00};
      endcase
   end
   logic [31:0] vec_reg;
   always_ff @(posedge I_CLOCK or negedge rst_n)
   begin
      if (!rst_n)
         vec_reg <= 32'h0000_0000;
      else
         vec_reg <= trap_base + vec_off;
   end
   assign O_VEC_ADDR = vec_reg;

   // ****************************************
   // axi4-lite slave
   // ****************************************
   logic aw_held_reg;
   logic w_held_reg;
   logic [31:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic wfull_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   wire aw_have = aw_held_reg || I_AWVALID;
   wire w_have = w_held_reg || I_WVALID;
   assign wr_addr = aw_held_reg ? awaddr_reg : I_AWADDR;
   assign bus_wdata = w_held_reg ? wdata_reg : I_WDATA;
   wire wr_go = aw_have && w_have && !bvalid_reg;
   // partial strobes are ignored, also when the data beat came early
   wire wr_full = w_held_reg ? wfull_reg : (&I_WSTRB);
   assign wr_fire = wr_go && wr_full && (wr_addr[31:4] == 28'h000_0000);
   wire wr_map = (wr_addr[3:0] == SSX_ADDR_PSW) || (wr_addr[3:0] == SSX_ADDR_BOOT);
   assign O_AWREADY = !aw_held_reg && !bvalid_reg;
   assign O_WREADY = !w_held_reg && !bvalid_reg;
   wire rd_go = I_ARVALID && !rvalid_reg;
   assign O_ARREADY = !rvalid_reg;
   wire [31:0] rd_word = (I_ARADDR[3:0] == SSX_ADDR_PSW) ? psw_reg
      : (I_ARADDR[3:0] == SSX_ADDR_BOOT) ? {31'h0000_0000, boot_ext_reg}
      : last_reg;
   wire rd_map = (I_ARADDR[31:4] == 28'h000_0000) && (I_ARADDR[1:0] == 2'b00)
      && (I_ARADDR[3:0] != 4'hC);

   always_ff @(posedge I_CLOCK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= 32'h0000_0000;
         wdata_reg <= 32'h0000_0000;
         wfull_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= SSX_RESP_OKAY;
      end
      else if (wr_go)
      begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         bvalid_reg <= 1'b1;
         bresp_reg <= (wr_map && wr_addr[31:4] == 28'h000_0000) ? SSX_RESP_OKAY : SSX_RESP_SLVERR;
      end
      else
      begin
         if (I_AWVALID && O_AWREADY)
         begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= I_AWADDR;
         end
         if (I_WVALID && O_WREADY)
         begin
            w_held_reg <= 1'b1;
            wdata_reg <= I_WDATA;
            wfull_reg <= &I_WSTRB;
         end
         if (I_BREADY)
            bvalid_reg <= 1'b0;
      end
   end

   always_ff @(posedge I_CLOCK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= SSX_RESP_OKAY;
      end
      else if (rd_go)
      begin
         rvalid_reg <= 1'b1;
         rdata_reg <= rd_map ? rd_word : 32'h0000_0000;
         rresp_reg <= rd_map ? SSX_RESP_OKAY : SSX_RESP_SLVERR;
      end
      else if (I_RREADY)
         rvalid_reg <= 1'b0;
   end
   assign O_BVALID = bvalid_reg;
   assign O_BRESP = bresp_reg;
   assign O_RVALID = rvalid_reg;
   assign O_RDATA = rdata_reg;
   assign O_RRESP = rresp_reg;

   // ****************************************
   // checks
   // ****************************************
   a_swap_bytes: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
      I_REQ.valid && I_REQ.op == SSX_OP_SWAP && no_ext |=> O_RES.data == swap_bytes($past(I_REQ.rs_val)))
      else $error("swap result wrong");
   a_sub_plain: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
      I_REQ.valid && I_REQ.op == SSX_OP_SUB_RR && no_ext
      |=> O_RES.rd_we && O_RES.data == $past(I_REQ.rd_val) - $past(I_REQ.rs_val))
      else $error("plain subtract wrong");
   a_sp_step: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
      I_REQ.valid && I_REQ.op == SSX_OP_SUB_SP && no_ext
      |=> O_RES.sp_we && !O_RES.rd_we && O_RES.data == $past(I_REQ.sp_val) - ($past(sp_step)))
      else $error("stack decrement wrong");
   a_delay_ext: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
      I_REQ.valid && I_REQ.delay_slot && !no_ext |=> O_RES.illegal && !O_RES.rd_we)
      else $error("prefixed delay slot accepted");
   a_xor_sign: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
      I_REQ.valid && I_REQ.op == SSX_OP_XOR_RI && no_ext
      |=> O_RES.data == ($past(I_REQ.rd_val) ^ {{26{$past(short_field[5])}}, $past(short_field)}))
      else $error("short xor wrong");
   a_zero_flag: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
      flag_upd && !psw_wr |=> psw_reg[SSX_PSW_Z] == (O_RES.data == 32'h0000_0000))
      else $error("zero flag wrong");
   a_trap_base: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
      I_VEC_SEL == 8'h00 && $stable(boot_ext_reg)
      |=> O_VEC_ADDR == ($past(boot_ext_reg) ? SSX_TRAP_BASE_EXT : SSX_TRAP_BASE_INT))
      else $error("trap base wrong");
   a_psw_resv: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
      psw_reg[31:12] == 20'h0_0000 && psw_reg[5] == 1'b0)
      else $error("reserved status bits set");
endmodule : ssx_datapath

// >>> pkg/ssx_pkg.sv
// Purpose: shared constants and types for the sub/swap/xor datapath
// Assumes: one clock, decoder supplies operands and prefix state
// Notes: register offsets on the axi4-lite slave are byte addresses
package ssx_pkg;
   // ****************************************
   // operations
   // ****************************************
   typedef enum logic [2:0] {SSX_OP_NONE, SSX_OP_SUB_RR, SSX_OP_SUB_RI, SSX_OP_SUB_SP,
      SSX_OP_SWAP, SSX_OP_XOR_RR, SSX_OP_XOR_RI} ssx_op_t;

   typedef struct packed {
      logic valid;
      ssx_op_t op;
      logic [1:0] ext_count;
      logic delay_slot;
      logic [12:0] prefix_first;
      logic [12:0] prefix_second;
      logic [9:0] field;
      logic [31:0] rd_val;
      logic [31:0] rs_val;
      logic [31:0] sp_val;
   } ssx_req_t;

   typedef struct packed {
      logic rd_we;
      logic sp_we;
      logic illegal;
      logic [31:0] data;
   } ssx_res_t;

   // ****************************************
   // trap table
   // ****************************************
   localparam logic [31:0] SSX_TRAP_BASE_INT = 32'h0008_0000;
   localparam logic [31:0] SSX_TRAP_BASE_EXT = 32'h00C0_0000;
   localparam logic [31:0] SSX_VEC_RESET = 32'h0000_0000;
   localparam logic [31:0] SSX_VEC_ZDIV = 32'h0000_0010;
   localparam logic [31:0] SSX_VEC_ADDR_ERR = 32'h0000_0018;
   localparam logic [31:0] SSX_VEC_NMI = 32'h0000_001C;
   localparam logic [31:0] SSX_VEC_SWEXC0 = 32'h0000_0030;
   localparam logic [31:0] SSX_VEC_EXTINT0 = 32'h0000_0040;
   localparam logic [7:0] SSX_EXTINT_LAST = 8'hD7;
   localparam logic [1:0] SSX_SWEXC_LAST = 2'h3;

   // ****************************************
   // status word layout and register map
   // ****************************************
   localparam int SSX_PSW_IL_LSB = 8;
   localparam int SSX_PSW_MO = 7;
   localparam int SSX_PSW_DS = 6;
   localparam int SSX_PSW_IE = 4;
   localparam int SSX_PSW_C = 3;
   localparam int SSX_PSW_V = 2;
   localparam int SSX_PSW_Z = 1;
   localparam int SSX_PSW_N = 0;
   localparam logic [31:0] SSX_PSW_WMASK = 32'h0000_0FDF;
   localparam logic [31:0] SSX_PSW_RESET = 32'h0000_0000;
   localparam logic [3:0] SSX_ADDR_PSW = 4'h0;
   localparam logic [3:0] SSX_ADDR_BOOT = 4'h4;
   localparam logic [3:0] SSX_ADDR_RESULT = 4'h8;
   localparam logic [1:0] SSX_RESP_OKAY = 2'b00;
   localparam logic [1:0] SSX_RESP_SLVERR = 2'b10;
endpackage : ssx_pkg

// >>> verif/ssx_datapath_tb.sv
// Purpose: self-checking bench for the sub/swap/xor datapath
// Assumes: 20 MHz clock, axi4-lite slave map as handed over
// Notes: expected results queued by the drivers, compared by a monitor
`timescale 1ns/1ps
module ssx_datapath_tb;
   import ssx_pkg::*;
   // ****************************************
   // signals
   // ****************************************
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   ssx_req_t req = '0;
   ssx_res_t res;
   logic [7:0] vec_sel = 8'h00;
   logic [31:0] vec_addr, psw, awaddr = '0, wdata = '0, araddr = '0, rdata;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [3:0] wstrb = 4'h0;
   logic [1:0] bresp, rresp;
   ssx_res_t res_q[$];
   logic [33:0] rd_q[$];
   int n_mismatch = 0, n_compared = 0, cyc = 0;
   always #25 clk = ~clk;
   ssx_datapath u_ssx_datapath (.I_CLOCK(clk), .I_RST_B(rst_b), .I_REQ(req), .O_RES(res),
      .I_VEC_SEL(vec_sel), .O_VEC_ADDR(vec_addr), .O_PSW(psw), .I_AWADDR(awaddr),
      .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb),
      .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
      .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
      .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready));
   // ****************************************
   // checking and closing
   // ****************************************
   task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
      n_compared++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic print_verdict();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : print_verdict
   // generous ceiling, the whole run needs well under 2000 cycles
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_mismatch++;
         print_verdict();
      end
   end
   always @(negedge clk)
   begin
      if ((res.rd_we | res.sp_we | res.illegal) === 1'b1)
      begin
         if (res_q.size() == 0)
            chk("spurious result", 34'h0, 34'h1);
         else
         begin
            chk("write enables", {31'h0, res_q[0].rd_we, res_q[0].sp_we, res_q[0].illegal},
               {31'h0, res.rd_we, res.sp_we, res.illegal});
            // refused requests carry no defined data
            if (!res_q[0].illegal)
               chk("result data", {2'b0, res_q[0].data}, {2'b0, res.data});
            void'(res_q.pop_front());
         end
      end
      if (rvalid === 1'b1 && rready && rd_q.size() > 0)
         chk("read resp,data", rd_q.pop_front(), {rresp, rdata});
   end
   // ****************************************
   // datapath driver
   // ****************************************
   function automatic ssx_req_t mk(input ssx_op_t op, input int e, input logic ds);
      ssx_req_t r;
      r.valid = 1'b1;
      r.op = op;
      r.ext_count = 2'(e);
      r.delay_slot = ds;
      r.prefix_first = 13'($urandom);
      r.prefix_second = 13'($urandom);
      r.field = 10'($urandom);
      r.rd_val = $urandom;
      r.rs_val = $urandom;
      r.sp_val = $urandom;
      return r;
   endfunction : mk
   task automatic send(input ssx_req_t r);
      ssx_res_t x;
      logic [12:0] a, b;
      logic [5:0] f;
      a = r.prefix_first;
      b = r.prefix_second;
      f = r.field[5:0];
      x.illegal = (r.ext_count != 0) && (r.op == SSX_OP_SUB_SP || r.op == SSX_OP_SWAP
         || r.delay_slot);
      x.sp_we = !x.illegal && r.op == SSX_OP_SUB_SP;
      x.rd_we = !x.illegal && r.op != SSX_OP_SUB_SP;
      case (r.op)
         SSX_OP_SUB_RR: x.data = (r.ext_count == 0) ? r.rd_val - r.rs_val :
            (r.ext_count == 1) ? r.rs_val - {19'h0, a} : r.rs_val - {6'h0, a, b};
         SSX_OP_SUB_RI: x.data = (r.ext_count == 0) ? r.rd_val - {26'h0, f} :
            (r.ext_count == 1) ? r.rd_val - {13'h0, a, f} : r.rd_val - {a, b, f};
         SSX_OP_XOR_RR: x.data = (r.ext_count == 0) ? r.rd_val ^ r.rs_val :
            (r.ext_count == 1) ? r.rs_val ^ {19'h0, a} : r.rs_val ^ {6'h0, a, b};
         SSX_OP_XOR_RI: x.data = (r.ext_count == 0) ? r.rd_val ^ {{26{f[5]}}, f} :
            (r.ext_count == 1) ? r.rd_val ^ {{13{a[12]}}, a, f} : r.rd_val ^ {a, b, f};
         SSX_OP_SUB_SP: x.data = r.sp_val - {20'h0, r.field, 2'b00};
         default: x.data = {r.rs_val[7:0], r.rs_val[15:8], r.rs_val[23:16], r.rs_val[31:24]};
      endcase
      req <= r;
      res_q.push_back(x);
      @(posedge clk);
   endtask : send
   task automatic idle();
      req <= '0;
      repeat (3) @(posedge clk);
   endtask : idle
   // ****************************************
   // axi4-lite master
   // ****************************************
   task automatic axi_write(input logic [31:0] ad, input logic [31:0] d, input logic [3:0] s,
      input logic [1:0] er);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      awaddr <= ad;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      // each channel held until its own ready is seen at a rising edge
      while (!(aw_done && w_done))
      begin
         @(posedge clk);
         if (!aw_done && awready === 1'b1)
         begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_done && wready === 1'b1)
         begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end
      bready <= 1'b1;
      do @(posedge clk); while (bvalid !== 1'b1);
      chk("write resp", {32'h0, er}, {32'h0, bresp});
      bready <= 1'b0;
   endtask : axi_write
   task automatic axi_read(input logic [31:0] ad, input logic [31:0] ed, input logic [1:0] er);
      araddr <= ad;
      arvalid <= 1'b1;
      rd_q.push_back({er, ed});
      do @(negedge clk); while (arready !== 1'b1);
      @(posedge clk);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do @(negedge clk); while (rvalid !== 1'b1);
      @(posedge clk);
      rready <= 1'b0;
   endtask : axi_read
   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      logic [7:0] sel[8] = '{8'h00, 8'h41, 8'h42, 8'h43, 8'h80, 8'h83, 8'hC0, 8'hD7};
      int off[8] = '{0, 16, 24, 28, 48, 60, 832, 924};
      ssx_req_t r;
      void'($urandom(32'hfda8));
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      axi_read(32'h0, SSX_PSW_RESET, SSX_RESP_OKAY);
      for (int o = 1; o <= 6; o++)
         for (int e = 0; e < 3; e++)
            repeat (4) send(mk(ssx_op_t'(o), e, 1'b0));
      for (int e = 0; e < 3; e++)
         for (int o = 1; o <= 6; o++)
            send(mk(ssx_op_t'(o), e, 1'b1));
      idle();
      axi_write(32'h0, 32'hFFFF_FFFF, 4'hF, SSX_RESP_OKAY);
      axi_read(32'h0, 32'h0000_0FDF, SSX_RESP_OKAY);
      r = mk(SSX_OP_XOR_RR, 0, 1'b0);
      r.rs_val = r.rd_val;
      send(r);
      idle();
      chk("psw zero", {2'b0, 32'h0000_0FDE}, {2'b0, psw});
      r = mk(SSX_OP_SUB_RI, 0, 1'b0);
      r.rd_val = 32'h0;
      r.field = 10'h001;
      send(r);
      idle();
      chk("psw borrow", {2'b0, 32'h0000_0FD9}, {2'b0, psw});
      axi_write(32'h0, 32'h0, 4'h3, SSX_RESP_OKAY);
      axi_read(32'h0, 32'h0000_0FD9, SSX_RESP_OKAY);
      axi_read(32'h8, 32'hFFFF_FFFF, SSX_RESP_OKAY);
      axi_write(32'hC, 32'h1, 4'hF, SSX_RESP_SLVERR);
      axi_read(32'hC, 32'h0, SSX_RESP_SLVERR);
      for (int bt = 0; bt < 2; bt++)
      begin
         axi_write(32'h4, 32'(bt), 4'hF, SSX_RESP_OKAY);
         axi_read(32'h4, 32'(bt), SSX_RESP_OKAY);
         for (int i = 0; i < 8; i++)
         begin
            vec_sel <= sel[i];
            @(posedge clk);
            @(negedge clk);
            chk("vector address", {2'b0, (bt ? SSX_TRAP_BASE_EXT : SSX_TRAP_BASE_INT) + off[i]},
               {2'b0, vec_addr});
            @(posedge clk);
         end
      end
      chk("results left", 34'h0, 34'(res_q.size() + rd_q.size()));
      print_verdict();
   end
endmodule : ssx_datapath_tb
